// ---- verilog/alu_bits_pkg.sv ----
package alu_bits_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned BUS_ADDR_W = 4;

  // software window onto the datapath state
  localparam logic [3:0] ACCUM_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // status layout
  localparam int unsigned CARRY_POS = 0;
  localparam int unsigned HALF_CARRY_POS = 1;
  localparam int unsigned ZERO_POS = 2;

  // file addresses with side effects
  localparam logic [6:0] IO_PORT_ADDR = 7'h06;
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;

  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [7:0] PINS_RESET = 8'h00;

  // destination select
  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [3:0] {
    op_none,
    add_immediate_op,
    add_file_op,
    and_immediate_op,
    and_file_op,
    bit_clear_op,
    bit_set_op,
    test_skip_if_zero,
    test_skip_if_one
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic [2:0] bit_idx;
    logic dest;
  } instr_t;

  typedef struct packed {
    logic zero;
    logic half_carry;
    logic carry;
  } status_t;

  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;
endpackage

// ---- verilog/add_and_bit_ops_datapath.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - literal add puts accumulator plus the 8-bit literal into the accumulator and updates carry, half carry, zero.
// - file add sums the accumulator with the addressed file register and updates carry, half carry, zero.
// - for file arithmetic and logic the destination bit sends the result to the accumulator at 0, the file at 1.
// - literal AND puts accumulator AND literal into the accumulator and updates only zero.
// - file AND sends accumulator AND file register to the chosen destination and updates only zero.
// - bit clear forces the indexed bit of the file register to 0, keeps the rest and touches no flag.
// - bit set forces the indexed bit of the file register to 1, keeps the rest and touches no flag.
// - test-skip-if-zero skips when the bit is 0, replacing the next instruction with a no-op, no flags.
// - test-skip-if-one skips when the bit is 1, replacing the next instruction with a no-op, no flags.
// - reading the I/O port register for modification takes the pin levels, not the latch.
// - a write to the timer count register clears the prescaler when it is assigned to the timer.
module add_and_bit_ops_datapath (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input alu_bits_pkg::instr_t instr,
  output logic [6:0] file_rd_addr,
  input wire logic [7:0] file_rd_data,
  output alu_bits_pkg::file_wr_t file_wr,
  input wire logic [7:0] io_pins,
  input wire logic prescaler_to_timer,
  output logic prescaler_clear,
  output logic skip_next,
  output logic [7:0] accum,
  output alu_bits_pkg::status_t status,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  logic [7:0] accum_q, accum_d;
  alu_bits_pkg::status_t status_q, status_d;
  alu_bits_pkg::file_wr_t file_wr_q, file_wr_d;
  logic skip_q, skip_d;
  logic presc_q, presc_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pins_q, pins_d;

  // pin synchroniser: a bit changes once stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_q <= alu_bits_pkg::PINS_RESET;
      pin_s2_q <= alu_bits_pkg::PINS_RESET;
      pin_s3_q <= alu_bits_pkg::PINS_RESET;
      pins_q <= alu_bits_pkg::PINS_RESET;
    end else begin
      pin_s1_q <= io_pins;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pins_q <= pins_d;
    end
  end
  assign pins_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pins_q & (pin_s2_q ^ pin_s3_q));

  // the instruction after a taken skip is discarded here
  wire exec = instr_valid && !skip_q && (instr.op != alu_bits_pkg::op_none);
  wire is_imm = (instr.op == alu_bits_pkg::add_immediate_op) || (instr.op == alu_bits_pkg::and_immediate_op);
  wire is_add = (instr.op == alu_bits_pkg::add_immediate_op) || (instr.op == alu_bits_pkg::add_file_op);
  wire is_and = (instr.op == alu_bits_pkg::and_immediate_op) || (instr.op == alu_bits_pkg::and_file_op);
  wire is_file_alu = (instr.op == alu_bits_pkg::add_file_op) || (instr.op == alu_bits_pkg::and_file_op);
  wire is_bit_wr = (instr.op == alu_bits_pkg::bit_clear_op) || (instr.op == alu_bits_pkg::bit_set_op);
  wire is_test = (instr.op == alu_bits_pkg::test_skip_if_zero) || (instr.op == alu_bits_pkg::test_skip_if_one);

  assign file_rd_addr = instr.file_addr;
  wire [7:0] file_val = (instr.file_addr == alu_bits_pkg::IO_PORT_ADDR) ? pins_q : file_rd_data;
  wire [7:0] opnd_b = is_imm ? instr.literal : file_val;
  wire [7:0] mask = bit_mask(instr.bit_idx);

  wire [8:0] sum9 = {1'b0, accum_q} + {1'b0, opnd_b};
  wire [4:0] half5 = {1'b0, accum_q[3:0]} + {1'b0, opnd_b[3:0]};
  wire [7:0] and_r = accum_q & opnd_b;
  wire [7:0] alu_r = is_add ? sum9[7:0] : and_r;
  wire [7:0] clr_r = file_val & ~mask;
  wire [7:0] set_r = file_val | mask;
  wire tested = |(file_val & mask);
  wire skip_take = exec && ((instr.op == alu_bits_pkg::test_skip_if_zero) ? !tested :
                            (instr.op == alu_bits_pkg::test_skip_if_one) && tested);

  wire to_file = exec && ((is_file_alu && instr.dest == alu_bits_pkg::DEST_FILE) || is_bit_wr);
  wire to_accum = exec && (is_imm || (is_file_alu && instr.dest == alu_bits_pkg::DEST_ACCUM));
  wire [7:0] file_res = !is_bit_wr ? alu_r : (instr.op == alu_bits_pkg::bit_set_op) ? set_r : clr_r;

  wire sel_accum = (reg_addr == alu_bits_pkg::ACCUM_OFFSET);
  wire sel_status = (reg_addr == alu_bits_pkg::STATUS_OFFSET);

  // execution takes priority over a software write in the same cycle
  assign accum_d = to_accum ? alu_r : (reg_wr && sel_accum) ? reg_wdata : accum_q;

  always_comb begin
    status_d = status_q;
    if (reg_wr && sel_status) begin
      status_d.carry = reg_wdata[alu_bits_pkg::CARRY_POS];
      status_d.half_carry = reg_wdata[alu_bits_pkg::HALF_CARRY_POS];
      status_d.zero = reg_wdata[alu_bits_pkg::ZERO_POS];
    end
    if (exec && is_add) begin
      status_d.carry = sum9[8];
      status_d.half_carry = half5[4];
    end
    if (exec && (is_add || is_and)) begin
      status_d.zero = (alu_r == 8'h00);
    end
  end

  assign file_wr_d = '{en: to_file, addr: instr.file_addr, data: file_res};
  assign skip_d = skip_take;
  assign presc_d = to_file && (instr.file_addr == alu_bits_pkg::TIMER_ZERO_ADDR) && prescaler_to_timer;

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd && sel_accum) begin
      rdata_d = accum_q;
    end else if (reg_rd && sel_status) begin
      rdata_d[alu_bits_pkg::CARRY_POS] = status_q.carry;
      rdata_d[alu_bits_pkg::HALF_CARRY_POS] = status_q.half_carry;
      rdata_d[alu_bits_pkg::ZERO_POS] = status_q.zero;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      accum_q <= alu_bits_pkg::ACCUM_RESET;
      status_q <= alu_bits_pkg::STATUS_RESET;
      file_wr_q <= '0;
      skip_q <= 1'b0;
      presc_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      accum_q <= accum_d;
      status_q <= status_d;
      file_wr_q <= file_wr_d;
      skip_q <= skip_d;
      presc_q <= presc_d;
      rdata_q <= rdata_d;
    end
  end

  assign file_wr = file_wr_q;
  assign skip_next = skip_q;
  assign prescaler_clear = presc_q;
  assign accum = accum_q;
  assign status = status_q;
  assign reg_rdata = rdata_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  wire add_imm_go = exec && (instr.op == alu_bits_pkg::add_immediate_op);
  wire and_go = exec && is_and;
  wire test_go = exec && is_test;

  sequence skip_slot;
    skip_next ##1 !skip_next;
  endsequence

  chk_add_imm_accum: assert property (add_imm_go |=> accum_q == $past(sum9[7:0]))
    else $error("literal add result wrong");
  chk_add_flags_carry: assert property (
    exec && is_add |=> status_q.carry == $past(sum9[8]) && status_q.half_carry == $past(half5[4]))
    else $error("add carry flags wrong");
  chk_file_add_sum: assert property (
    exec && instr.op == alu_bits_pkg::add_file_op |-> alu_r == accum_q + file_val)
    else $error("file add sum wrong");
  chk_dest_file_route: assert property (
    exec && is_file_alu && instr.dest == alu_bits_pkg::DEST_FILE && !(reg_wr && sel_accum)
    |=> file_wr_q.en && file_wr_q.addr == $past(instr.file_addr) && file_wr_q.data == $past(alu_r)
    && $stable(accum_q))
    else $error("file destination routing wrong");
  chk_dest_accum_route: assert property (
    exec && is_file_alu && instr.dest == alu_bits_pkg::DEST_ACCUM |=> !file_wr_q.en && accum_q == $past(alu_r))
    else $error("accumulator destination routing wrong");
  chk_and_imm_accum: assert property (
    exec && instr.op == alu_bits_pkg::and_immediate_op |=> accum_q == ($past(accum_q) & $past(instr.literal)))
    else $error("literal AND result wrong");
  chk_and_flags_only: assert property (
    and_go && !(reg_wr && sel_status) |=> $stable(status_q.carry) && $stable(status_q.half_carry))
    else $error("AND touched carry flags");
  chk_and_zero_flag: assert property (and_go |=> status_q.zero == ($past(and_r) == 8'h00))
    else $error("AND zero flag wrong");
  chk_file_and_val: assert property (
    exec && instr.op == alu_bits_pkg::and_file_op |-> alu_r == (accum_q & file_val))
    else $error("file AND result wrong");
  chk_bit_clear_val: assert property (
    exec && instr.op == alu_bits_pkg::bit_clear_op
    |=> file_wr_q.en && file_wr_q.data == ($past(file_val) & ~(8'h01 << $past(instr.bit_idx))))
    else $error("bit clear value wrong");
  chk_bit_set_val: assert property (
    exec && instr.op == alu_bits_pkg::bit_set_op
    |=> file_wr_q.en && file_wr_q.data == ($past(file_val) | (8'h01 << $past(instr.bit_idx))))
    else $error("bit set value wrong");
  chk_bit_flags_kept: assert property (
    exec && (is_bit_wr || is_test) && !(reg_wr && sel_status) |=> $stable(status_q))
    else $error("bit operation changed a flag");
  chk_skip_zero_seq: assert property (
    exec && instr.op == alu_bits_pkg::test_skip_if_zero && !tested |-> ##1 skip_slot)
    else $error("skip on zero not taken");
  chk_skip_one_seq: assert property (
    exec && instr.op == alu_bits_pkg::test_skip_if_one && tested |-> ##1 skip_slot)
    else $error("skip on one not taken");
  chk_no_skip_path: assert property (test_go && !skip_take |=> !skip_next && !file_wr_q.en)
    else $error("skip taken wrongly");
  chk_skip_discard: assert property (
    skip_next && instr_valid && !reg_wr |=> !file_wr_q.en && $stable(accum_q) && !skip_next)
    else $error("skipped instruction executed");
  chk_io_pin_read: assert property (
    exec && instr.op == alu_bits_pkg::bit_set_op && instr.file_addr == alu_bits_pkg::IO_PORT_ADDR
    |=> file_wr_q.data == ($past(pins_q) | (8'h01 << $past(instr.bit_idx))))
    else $error("port read did not use pins");
  chk_timer_presc: assert property (
    to_file && instr.file_addr == alu_bits_pkg::TIMER_ZERO_ADDR && prescaler_to_timer |=> prescaler_clear)
    else $error("prescaler clear missing");
  chk_presc_cause: assert property (
    prescaler_clear |-> file_wr_q.en && file_wr_q.addr == alu_bits_pkg::TIMER_ZERO_ADDR
    && $past(prescaler_to_timer))
    else $error("prescaler clear without timer write");
  chk_zero_result: assert property (add_imm_go |=> status_q.zero == (accum_q == 8'h00))
    else $error("zero flag mismatch");
  chk_half_carry_out: assert property (
    exec && is_add
    |=> status_q.half_carry == (({1'b0, $past(accum_q[3:0])} + {1'b0, $past(opnd_b[3:0])}) > 5'h0F))
    else $error("half carry flag wrong");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside a read");
endmodule // add_and_bit_ops_datapath

// ---- tb/file_mem_model.sv ----
`timescale 1ns/1ps
module file_mem_model (
  input wire logic mclk,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data,
  input alu_bits_pkg::file_wr_t wr
);
  // cleared at start so an operand never reads unknown
  logic [7:0] mem [128] = '{default: 8'h00};
  // combinational read, write one edge after the request
  assign rd_data = mem[rd_addr];
  always @(posedge mclk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end
endmodule // file_mem_model

// ---- tb/tb_add_and_bit_ops_datapath.sv ----
`timescale 1ns/1ps
module tb_add_and_bit_ops_datapath;
  logic mclk, rst_n, instr_valid, prescaler_to_timer, prescaler_clear, skip_next, reg_wr, reg_rd, c, h, z;
  alu_bits_pkg::instr_t instr;
  alu_bits_pkg::file_wr_t file_wr;
  alu_bits_pkg::status_t status;
  logic [6:0] file_rd_addr;
  logic [7:0] file_rd_data, io_pins, accum, reg_wdata, reg_rdata, w;
  logic [3:0] reg_addr;
  logic [8:0] s;
  int failures, checks_done;
  add_and_bit_ops_datapath u_dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data), .file_wr(file_wr), .io_pins(io_pins),
    .prescaler_to_timer(prescaler_to_timer), .prescaler_clear(prescaler_clear), .skip_next(skip_next),
    .accum(accum), .status(status), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  file_mem_model u_mem (.mclk(mclk), .rd_addr(file_rd_addr), .rd_data(file_rd_data), .wr(file_wr));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic st;
    chk({5'h00, status}, {5'h00, z, h, c});
  endtask
  // let any pending file write land before preloading
  task automatic ld(input logic [6:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    u_mem.mem[a] = v;
  endtask
  task automatic put(input alu_bits_pkg::op_t op, input logic [7:0] k, input logic [6:0] f, input logic [2:0] b,
                     input logic d);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr <= '{op, k, f, b, d};
  endtask
  task automatic done;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic ex(input alu_bits_pkg::op_t op, input logic [7:0] k, input logic [6:0] f, input logic [2:0] b,
                    input logic d);
    put(op, k, f, b, d);
    done;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic alu(input logic a, input logic fl, input logic [7:0] v, input logic d);
    if (fl) begin
      ld(7'h20, v);
    end
    s = a ? {1'b0, w} + {1'b0, v} : {1'b0, w & v};
    if (a) begin
      c = s[8];
      h = ({1'b0, w[3:0]} + {1'b0, v[3:0]}) > 5'h0F;
    end
    z = s[7:0] == 8'h00;
    ex(a ? (fl ? alu_bits_pkg::add_file_op : alu_bits_pkg::add_immediate_op)
         : (fl ? alu_bits_pkg::and_file_op : alu_bits_pkg::and_immediate_op), v, 7'h20, 3'h0, d);
    if (d) begin
      chk({file_wr.en, file_wr.addr}, 8'hA0);
      chk(file_wr.data, s[7:0]);
    end else begin
      w = s[7:0];
    end
    chk(accum, w);
    st;
  endtask
  initial begin
    #1000000;
    failures++;
    results;
  end
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    io_pins = 8'h00;
    prescaler_to_timer = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    failures = 0;
    checks_done = 0;
    {c, h, z} = 3'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk(accum, 8'h00);
    st;
    rreg(4'h8, 8'h00);
    wreg(alu_bits_pkg::ACCUM_OFFSET, 8'h0F);
    w = 8'h0F;
    rreg(alu_bits_pkg::ACCUM_OFFSET, 8'h0F);
    alu(1'b1, 1'b0, 8'h01, 1'b0);
    alu(1'b1, 1'b0, 8'hF0, 1'b0);
    alu(1'b1, 1'b1, 8'h7F, 1'b0);
    alu(1'b1, 1'b1, 8'h81, 1'b1);
    alu(1'b0, 1'b1, 8'h3C, 1'b1);
    alu(1'b0, 1'b1, 8'h0F, 1'b0);
    alu(1'b0, 1'b0, 8'hF0, 1'b0);
    rreg(alu_bits_pkg::STATUS_OFFSET, {5'h00, z, h, c});
    for (int b = 0; b < 8; b++) begin
      ld(7'h31, 8'h5A);
      ex(alu_bits_pkg::bit_set_op, 8'h00, 7'h31, b[2:0], 1'b1);
      chk(file_wr.data, 8'h5A | (8'h01 << b));
      ex(alu_bits_pkg::bit_clear_op, 8'h00, 7'h31, b[2:0], 1'b1);
      chk(file_wr.data, 8'h5A & ~(8'h01 << b));
      st;
    end
    // the slot after a taken skip carries a bit set that must vanish
    for (int i = 0; i < 4; i++) begin
      ld(7'h40, {7'h00, i[0]});
      put(i[1] ? alu_bits_pkg::test_skip_if_one : alu_bits_pkg::test_skip_if_zero, 8'h00, 7'h40, 3'h0, 1'b0);
      put(alu_bits_pkg::bit_set_op, 8'h00, 7'h41, 3'h0, 1'b1);
      #1;
      chk({7'h00, skip_next}, {7'h00, i[0] == i[1]});
      done;
      chk({6'h00, skip_next, file_wr.en}, {6'h00, 1'b0, i[0] != i[1]});
      st;
    end
    @(posedge mclk);
    io_pins <= 8'hA5;
    repeat (6) @(posedge mclk);
    ld(alu_bits_pkg::IO_PORT_ADDR, 8'h00);
    ex(alu_bits_pkg::bit_set_op, 8'h00, alu_bits_pkg::IO_PORT_ADDR, 3'h1, 1'b1);
    chk(file_wr.data, 8'hA7);
    for (int p = 0; p < 2; p++) begin
      @(posedge mclk);
      prescaler_to_timer <= p[0];
      ex(alu_bits_pkg::bit_clear_op, 8'h00, alu_bits_pkg::TIMER_ZERO_ADDR, 3'h0, 1'b1);
      chk({7'h00, prescaler_clear}, {7'h00, p[0]});
    end
    // result kept in the accumulator: the timer count is not written
    ex(alu_bits_pkg::and_file_op, 8'h00, alu_bits_pkg::TIMER_ZERO_ADDR, 3'h0, 1'b0);
    chk({7'h00, prescaler_clear}, 8'h00);
    // reset in mid-run, then an add straight after release
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    w = 8'h00;
    {c, h, z} = 3'h0;
    chk(accum, 8'h00);
    st;
    alu(1'b1, 1'b0, 8'h8F, 1'b0);
    results;
  end
endmodule // tb_add_and_bit_ops_datapath
